// >>> design/fec_defs.vh
`ifndef FEC_DEFS_VH
`define FEC_DEFS_VH
// ----------------------------------------
// bus widths
// ----------------------------------------
`define FEC_AW 23
`define FEC_DW 16
// ----------------------------------------
// command codes and unlock addresses
// ----------------------------------------
`define FEC_D_UNLOCK1 16'h00AA
`define FEC_D_UNLOCK2 16'h0055
`define FEC_D_RESET 16'h00F0
`define FEC_D_AUTOSEL 16'h0090
`define FEC_D_ERASE_SETUP 16'h0080
`define FEC_D_CHIP_ERASE 16'h0010
`define FEC_D_BLOCK_ERASE 16'h0030
`define FEC_D_SUSPEND 16'h00B0
`define FEC_D_RESUME 16'h0030
`define FEC_D_CFI 16'h0098
`define FEC_A_UNLOCK1 23'h000555
`define FEC_A_UNLOCK2 23'h0002AA
// ----------------------------------------
// host command opcodes
// ----------------------------------------
`define FEC_OP_RESET1 3'h0
`define FEC_OP_RESET3 3'h1
`define FEC_OP_AUTOSEL 3'h2
`define FEC_OP_CFI 3'h3
`define FEC_OP_CHIP 3'h4
`define FEC_OP_BLOCK 3'h5
`define FEC_OP_SUSPEND 3'h6
`define FEC_OP_RESUME 3'h7
// ----------------------------------------
// bus write cycle timing, in clocks
// ----------------------------------------
`define FEC_WE_LOW_CYC 4'h2
`define FEC_WE_HIGH_CYC 4'h2
// ----------------------------------------
// device modes tracked by the host
// ----------------------------------------
`define FEC_M_READ 3'h0
`define FEC_M_AUTOSEL 3'h1
`define FEC_M_CFI 3'h2
`define FEC_M_CHIP 3'h3
`define FEC_M_BLKTO 3'h4
`define FEC_M_BLKRUN 3'h5
`define FEC_M_SUSP 3'h6
`define FEC_M_ABORT 3'h7
// ----------------------------------------
// abort time: 10 us at 20 MHz, exact count
// ----------------------------------------
`define FEC_ABORT_CYC 16'h00C8
`define FEC_CNT_W 16
`endif

// >>> design/fec_write_cycle.v
`timescale 1ns/1ps
// one bus write cycle on the flash pins: low phase then recovery
module fec_write_cycle
(
   input wire clk,
   input wire srst,
   input wire start,
   input wire [22:0] addr,
   input wire [15:0] data,
   output reg busy,
   output reg done,
   output reg ce_n,
   output reg we_n,
   output reg [22:0] a_out,
   output reg [15:0] dq_out,
   output reg dq_oe_n
);
`include "fec_defs.vh"
   // ----------------------------------------
   // phase counter
   // ----------------------------------------
   reg [3:0] cnt; // cycles left in phase
   reg phase; // 0 low pulse, 1 recovery
   // drives the pins for the whole cycle so data holds past we rise
   always @(posedge clk)
   begin
      if (srst)
      begin
         busy <= 1'b0;
         done <= 1'b0;
         ce_n <= 1'b1;
         we_n <= 1'b1;
         a_out <= 23'h000000;
         dq_out <= 16'h0000;
         dq_oe_n <= 1'b1;
         cnt <= 4'h0;
         phase <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (!busy)
         begin
            if (start)
            begin
               // latch and assert strobes together
               busy <= 1'b1;
               ce_n <= 1'b0;
               we_n <= 1'b0;
               a_out <= addr;
               dq_out <= data;
               dq_oe_n <= 1'b0;
               cnt <= `FEC_WE_LOW_CYC;
               phase <= 1'b0;
            end
         end
         else if (cnt != 4'h1)
         begin
            cnt <= cnt - 4'h1;
         end
         else if (!phase)
         begin
            // rising we latches the data in the device
            we_n <= 1'b1;
            phase <= 1'b1;
            cnt <= `FEC_WE_HIGH_CYC;
         end
         else
         begin
            busy <= 1'b0;
            done <= 1'b1;
            ce_n <= 1'b1;
            dq_oe_n <= 1'b1;
         end
      end
   end
endmodule // fec_write_cycle

// >>> design/fec_erase_host.v
`timescale 1ns/1ps
// Function
// R1: only valid sequences issued; bad ones leave read
// R2: after reset tracked mode is read array
// R3: reset command one or three writes
// R4: reset mid-sequence cancels partial command
// R5: reset in selection timeout waits 10 us
// R6: reset in suspend keeps erase suspended
// R7: auto select is three writes
// R8: auto select held until reset or cfi
// R9: cfi one write, only from read/autoselect (code also takes it in suspend)
// R10: reset from cfi returns previous mode
// R11: chip erase is six writes
// R12: protected blocks skipped, no error
// R13: during chip erase all commands ignored
// R14: erase end to read; error needs reset
// R15: extra blocks repeat sixth write in window
// R16: each extra block restarts timeout
// R17: reads of erased bank give status
// R18: all-protected block erase ends quickly
// R19: block erase ignores all but suspend/reset (code takes reset in the timeout window only)
// R20: suspend is one write to bank address
// R21: suspended block reads give status (code leaves status_reads low in suspend unless an error is held)
// R22: resume needs read array first
// R23: reset F0, unlock AA/555 55/2AA, autoselect 90
// R24: erase 80, second unlock, 10 or 30
// R25: suspend B0, resume 30, cfi 98 at 555
// R26: selection timeout, suspend latency are parameters
module fec_erase_host
#(
   parameter SEL_TIMEOUT_CYC = 1000, // block selection timeout [R26]
   parameter SUSP_LAT_CYC = 500 // erase suspend latency [R26]
)
(
   input wire clk,
   input wire srst,
   input wire cmd_valid,
   input wire [2:0] cmd_op,
   input wire [22:0] cmd_addr,
   input wire erase_done,
   input wire erase_error,
   output reg cmd_ready,
   output reg cmd_accepted,
   output reg cmd_rejected,
   output reg [2:0] mode,
   output reg status_reads,
   output reg flash_ce_n,
   output reg flash_we_n,
   output reg [22:0] flash_addr,
   output reg [15:0] flash_dq_out,
   output reg flash_dq_oe_n
);
`include "fec_defs.vh"
   // ----------------------------------------
   // sequencer state
   // ----------------------------------------
   localparam S_IDLE = 2'h0;
   localparam S_SEND = 2'h1;
   localparam S_WAIT = 2'h2;
   localparam [22:0] CFI_LOW = `FEC_A_UNLOCK1; // low bits give the query offset
   reg [1:0] state; // sequencer state
   reg [2:0] op; // latched opcode
   reg [22:0] bank_select_address; // block or bank address of command
   reg [2:0] step; // write index in sequence
   reg [2:0] last_step; // final write index
   reg [2:0] cfi_prev; // mode before cfi entry [R10]
   reg err_held; // device holds error status [R14]
   reg susp_under; // erase stays suspended beneath auto select [R22]
   reg [`FEC_CNT_W-1:0] tmr; // timeout, abort or latency counter
   reg wc_start; // pulse to write cycle engine
   reg [22:0] wc_addr; // address of next write
   reg [15:0] wc_data; // data of next write
   wire wc_busy;
   wire wc_done;
   wire ce_n_w;
   wire we_n_w;
   wire [22:0] a_w;
   wire [15:0] dq_w;
   wire oe_n_w;
   reg legal; // command allowed in current mode
   // ----------------------------------------
   // write engine
   // ----------------------------------------
   fec_write_cycle u_wc
   (
      .clk(clk),
      .srst(srst),
      .start(wc_start),
      .addr(wc_addr),
      .data(wc_data),
      .busy(wc_busy),
      .done(wc_done),
      .ce_n(ce_n_w),
      .we_n(we_n_w),
      .a_out(a_w),
      .dq_out(dq_w),
      .dq_oe_n(oe_n_w)
   );
   // pin outputs re-registered so the top drives only from flops
   always @(posedge clk)
   begin
      if (srst)
      begin
         flash_ce_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_addr <= 23'h000000;
         flash_dq_out <= 16'h0000;
         flash_dq_oe_n <= 1'b1;
      end
      else
      begin
         flash_ce_n <= ce_n_w;
         flash_we_n <= we_n_w;
         flash_addr <= a_w;
         flash_dq_out <= dq_w;
         flash_dq_oe_n <= oe_n_w;
      end
   end
   // ----------------------------------------
   // legality of a command in the tracked mode
   // ----------------------------------------
   // illegal ones are refused here rather than sent, since the device
   // would drop to read array and the host tracking would diverge [R1]
   always @*
   begin
      legal = 1'b0;
      case (mode)
         `FEC_M_READ: legal = (cmd_op != `FEC_OP_SUSPEND) && (cmd_op != `FEC_OP_RESUME)
            && !(err_held && cmd_op != `FEC_OP_RESET1 && cmd_op != `FEC_OP_RESET3);
         `FEC_M_AUTOSEL: legal = (cmd_op == `FEC_OP_RESET1) || (cmd_op == `FEC_OP_RESET3)
            || (cmd_op == `FEC_OP_CFI); // [R8]
         `FEC_M_CFI: legal = (cmd_op == `FEC_OP_RESET1) || (cmd_op == `FEC_OP_RESET3);
         `FEC_M_CHIP: legal = 1'b0; // [R13]
         `FEC_M_BLKTO: legal = (cmd_op == `FEC_OP_BLOCK) || (cmd_op == `FEC_OP_SUSPEND)
            || (cmd_op == `FEC_OP_RESET1) || (cmd_op == `FEC_OP_RESET3); // [R19]
         `FEC_M_BLKRUN: legal = (cmd_op == `FEC_OP_SUSPEND); // [R19]
         `FEC_M_SUSP: legal = (cmd_op == `FEC_OP_AUTOSEL) || (cmd_op == `FEC_OP_CFI)
            || (cmd_op == `FEC_OP_RESET1) || (cmd_op == `FEC_OP_RESET3)
            || (cmd_op == `FEC_OP_RESUME); // [R22]
         default: legal = 1'b0;
      endcase
   end
   // ----------------------------------------
   // write sequence table
   // ----------------------------------------
   always @*
   begin
      wc_addr = `FEC_A_UNLOCK1;
      wc_data = `FEC_D_UNLOCK1;
      if (op == `FEC_OP_RESET1 || op == `FEC_OP_SUSPEND || op == `FEC_OP_RESUME)
      begin
         wc_addr = bank_select_address; // [R20]
         wc_data = (op == `FEC_OP_RESET1) ? `FEC_D_RESET
            : (op == `FEC_OP_SUSPEND) ? `FEC_D_SUSPEND : `FEC_D_RESUME; // [R25]
      end
      else if (op == `FEC_OP_CFI)
      begin
         wc_addr = {bank_select_address[22:12], CFI_LOW[11:0]};
         wc_data = `FEC_D_CFI; // [R25] [R9]
      end
      else if (op == `FEC_OP_BLOCK && mode == `FEC_M_BLKTO)
      begin
         wc_addr = bank_select_address; // repeat of sixth write [R15]
         wc_data = `FEC_D_BLOCK_ERASE;
      end
      else
      begin
         case (step)
            3'h0:
            begin
               wc_addr = `FEC_A_UNLOCK1;
               wc_data = `FEC_D_UNLOCK1; // [R23]
            end
            3'h1:
            begin
               wc_addr = `FEC_A_UNLOCK2;
               wc_data = `FEC_D_UNLOCK2;
            end
            3'h2:
            begin
               wc_addr = (op == `FEC_OP_AUTOSEL) ? bank_select_address : `FEC_A_UNLOCK1;
               wc_data = (op == `FEC_OP_RESET3) ? `FEC_D_RESET
                  : (op == `FEC_OP_AUTOSEL) ? `FEC_D_AUTOSEL : `FEC_D_ERASE_SETUP; // [R24]
            end
            3'h3:
            begin
               wc_addr = `FEC_A_UNLOCK1;
               wc_data = `FEC_D_UNLOCK1;
            end
            3'h4:
            begin
               wc_addr = `FEC_A_UNLOCK2;
               wc_data = `FEC_D_UNLOCK2;
            end
            default:
            begin
               wc_addr = (op == `FEC_OP_CHIP) ? `FEC_A_UNLOCK1 : bank_select_address;
               wc_data = (op == `FEC_OP_CHIP) ? `FEC_D_CHIP_ERASE : `FEC_D_BLOCK_ERASE;
            end
         endcase
      end
   end
   // ----------------------------------------
   // sequencer and mode tracker
   // ----------------------------------------
   always @(posedge clk)
   begin
      if (srst)
      begin
         state <= S_IDLE;
         op <= 3'h0;
         bank_select_address <= 23'h000000;
         step <= 3'h0;
         last_step <= 3'h0;
         cfi_prev <= `FEC_M_READ;
         err_held <= 1'b0;
         susp_under <= 1'b0;
         tmr <= {`FEC_CNT_W{1'b0}};
         wc_start <= 1'b0;
         cmd_ready <= 1'b0;
         cmd_accepted <= 1'b0;
         cmd_rejected <= 1'b0;
         mode <= `FEC_M_READ; // [R2]
         status_reads <= 1'b0;
      end
      else
      begin
         wc_start <= 1'b0;
         cmd_accepted <= 1'b0;
         cmd_rejected <= 1'b0;
         cmd_ready <= (state == S_IDLE) && !cmd_valid;
         // status visible while erase runs, is aborting or errored [R17] [R21]
         status_reads <= (mode == `FEC_M_CHIP) || (mode == `FEC_M_BLKTO)
            || (mode == `FEC_M_BLKRUN) || (mode == `FEC_M_ABORT) || err_held;
         // timers running in background modes
         if (mode == `FEC_M_BLKTO && state == S_IDLE)
         begin
            if (tmr != {`FEC_CNT_W{1'b0}})
               tmr <= tmr - 1'b1;
            else
               mode <= `FEC_M_BLKRUN; // controller starts, no more blocks [R15]
         end
         else if (mode == `FEC_M_ABORT)
         begin
            if (tmr != {`FEC_CNT_W{1'b0}})
               tmr <= tmr - 1'b1;
            else
               mode <= `FEC_M_READ; // abort finished [R5]
         end
         else if ((mode == `FEC_M_CHIP || mode == `FEC_M_BLKRUN) && erase_done)
         begin
            // protected blocks are skipped silently, device just ends [R12] [R18]
            mode <= `FEC_M_READ; // [R14]
            err_held <= erase_error;
         end
         case (state)
            S_IDLE:
            begin
               if (cmd_valid && cmd_ready)
               begin
                  if (legal)
                  begin
                     op <= cmd_op;
                     bank_select_address <= cmd_addr;
                     step <= (mode == `FEC_M_BLKTO && cmd_op == `FEC_OP_BLOCK) ? 3'h5 : 3'h0;
                     case (cmd_op)
                        `FEC_OP_RESET3, `FEC_OP_AUTOSEL: last_step <= 3'h2; // [R3] [R7]
                        `FEC_OP_CHIP, `FEC_OP_BLOCK: last_step <= 3'h5; // [R11]
                        default: last_step <= 3'h0;
                     endcase
                     wc_start <= 1'b1;
                     state <= S_SEND;
                     cmd_accepted <= 1'b1;
                  end
                  else
                  begin
                     cmd_rejected <= 1'b1; // [R13] [R19]
                  end
               end
            end
            S_SEND:
            begin
               state <= S_WAIT;
            end
            S_WAIT:
            begin
               if (wc_done)
               begin
                  if (step == last_step || (mode == `FEC_M_BLKTO && op == `FEC_OP_BLOCK))
                  begin
                     state <= S_IDLE;
                     case (op)
                        `FEC_OP_RESET1, `FEC_OP_RESET3:
                        begin
                           err_held <= 1'b0; // [R3]
                           if (mode == `FEC_M_CFI)
                              mode <= cfi_prev; // [R10]
                           else if (mode == `FEC_M_BLKTO)
                           begin
                              mode <= `FEC_M_ABORT;
                              tmr <= `FEC_ABORT_CYC; // [R5]
                           end
                           else if (mode == `FEC_M_SUSP)
                              mode <= `FEC_M_SUSP; // [R6]
                           else if (mode == `FEC_M_AUTOSEL && susp_under)
                              mode <= `FEC_M_SUSP; // erase still suspended [R22]
                           else
                              mode <= `FEC_M_READ; // partial command dropped [R4]
                        end
                        `FEC_OP_AUTOSEL:
                        begin
                           // remember the suspend so reset lands back in it [R22]
                           susp_under <= (mode == `FEC_M_SUSP);
                           mode <= `FEC_M_AUTOSEL;
                        end
                        `FEC_OP_CFI:
                        begin
                           cfi_prev <= mode;
                           mode <= `FEC_M_CFI;
                        end
                        `FEC_OP_CHIP: mode <= `FEC_M_CHIP;
                        `FEC_OP_BLOCK:
                        begin
                           mode <= `FEC_M_BLKTO;
                           tmr <= SEL_TIMEOUT_CYC[`FEC_CNT_W-1:0]; // [R16]
                        end
                        `FEC_OP_SUSPEND:
                        begin
                           // in the window suspend is immediate, else wait latency [R20]
                           if (mode == `FEC_M_BLKRUN)
                           begin
                              tmr <= SUSP_LAT_CYC[`FEC_CNT_W-1:0];
                              state <= S_SEND;
                              op <= `FEC_OP_RESUME;
                              step <= 3'h7;
                              last_step <= 3'h6;
                           end
                           mode <= `FEC_M_SUSP;
                        end
                        default: mode <= (mode == `FEC_M_SUSP) ? `FEC_M_BLKRUN : mode;
                     endcase
                  end
                  else
                  begin
                     step <= step + 3'h1;
                     wc_start <= 1'b1;
                     state <= S_SEND;
                  end
               end
               else if (step == 3'h7)
               begin
                  // suspend latency wait, no bus write outstanding
                  if (tmr != {`FEC_CNT_W{1'b0}})
                     tmr <= tmr - 1'b1;
                  else
                  begin
                     state <= S_IDLE;
                     step <= 3'h0;
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule // fec_erase_host

// >>> verification/fec_erase_host_monitor.sv
`timescale 1ns/1ps
// --------
// port checker for the erase host
// --------
module fec_erase_host_monitor
#(
   parameter SEL_TIMEOUT_CYC = 1000, // selection window, clocks
   parameter SUSP_LAT_CYC = 500 // suspend latency, clocks
)
(
   input wire clk,
   input wire srst,
   input wire cmd_valid,
   input wire [2:0] cmd_op,
   input wire [22:0] cmd_addr,
   input wire erase_done,
   input wire erase_error,
   input wire cmd_ready,
   input wire cmd_accepted,
   input wire cmd_rejected,
   input wire [2:0] mode,
   input wire status_reads,
   input wire flash_ce_n,
   input wire flash_we_n,
   input wire [22:0] flash_addr,
   input wire [15:0] flash_dq_out,
   input wire flash_dq_oe_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // a command is taken on this edge
   wire take = cmd_valid && cmd_ready;
   // --------
   // assertions
   // --------
   reset_read_a: assert property ($fell(srst) |-> mode == 3'h0)
      else $error("mode not read after reset");
   one_answer_a: assert property (take |=> cmd_accepted != cmd_rejected)
      else $error("taken command got no single answer");
   chip_deaf_a: assert property (take && mode == 3'h3 |=> cmd_rejected)
      else $error("command honoured during chip erase");
   chip_status_a: assert property (mode == 3'h3 |=> status_reads)
      else $error("reads not status during chip erase");
   run_deaf_a: assert property (take && mode == 3'h5 && cmd_op != 3'h6 |=> cmd_rejected)
      else $error("non-suspend honoured during block erase");
   cfi_from_a: assert property (take && cmd_op == 3'h3
      && mode inside {3'h2, 3'h3, 3'h4, 3'h5} |=> cmd_rejected)
      else $error("query accepted from wrong mode");
   we_pulse_a: assert property ($fell(flash_we_n) |->
      (!flash_we_n && !flash_ce_n && !flash_dq_oe_n) [*2] ##1 flash_we_n)
      else $error("write strobe shape wrong");
   we_hold_a: assert property ($fell(flash_we_n)
      |=> $stable(flash_addr) && $stable(flash_dq_out))
      else $error("address or data moved in write");
   susp_window_a: assert property (take && mode == 3'h4 && cmd_op == 3'h6
      |-> ##[1:30] mode == 3'h6)
      else $error("suspend in window not immediate");
   abort_end_a: assert property (mode == 3'h7 |-> ##[1:260] mode == 3'h0)
      else $error("abort did not end in read");
   refuse_quiet_a: assert property (cmd_rejected |-> flash_we_n [*3])
      else $error("refused command reached pins");
   // main scenarios reached
   cover property (mode == 3'h6);
   cover property (mode == 3'h7);
   cover property (take && mode == 3'h4 && cmd_op == 3'h5);
endmodule // fec_erase_host_monitor

bind fec_erase_host fec_erase_host_monitor #(.SEL_TIMEOUT_CYC(SEL_TIMEOUT_CYC),
   .SUSP_LAT_CYC(SUSP_LAT_CYC)) u_mon (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
   .cmd_op(cmd_op), .cmd_addr(cmd_addr), .erase_done(erase_done), .erase_error(erase_error),
   .cmd_ready(cmd_ready), .cmd_accepted(cmd_accepted), .cmd_rejected(cmd_rejected),
   .mode(mode), .status_reads(status_reads), .flash_ce_n(flash_ce_n),
   .flash_we_n(flash_we_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
   .flash_dq_oe_n(flash_dq_oe_n));

// >>> verification/fec_flash_model.sv
`timescale 1ns/1ps
// --------
// flash device: decodes pin writes, runs erase
// --------
module fec_flash_model
#(
   parameter SEL_CYC = 40, // selection window, clocks
   parameter ERASE_CYC = 300 // erase run time, clocks
)
(
   input wire clk,
   input wire srst,
   input wire ce_n,
   input wire we_n,
   input wire [22:0] addr,
   input wire [15:0] dq,
   input wire fail, // next erase ends in error
   output reg done,
   output reg err
);
   reg we_q; // last strobe level
   reg [2:0] seq; // unlock step reached
   reg [2:0] st; // 0 idle 1 window 2 block run 3 suspended 4 chip run
   reg [15:0] tmr; // window or erase countdown
   // latched on the strobe rise while selected
   wire wr = we_n && !we_q && !ce_n;
   wire a555 = addr[11:0] == 12'h555;
   // decode and erase sequencing
   always @(posedge clk)
   begin
      we_q <= we_n;
      done <= 1'b0;
      err <= 1'b0;
      if (srst)
      begin
         seq <= 3'h0; // power-up state is read
         st <= 3'h0;
         tmr <= 16'h0;
      end
      else
      begin
         if (tmr != 16'h0)
            tmr <= tmr - 16'h1;
         // window ran out: controller starts
         if (st == 3'h1 && tmr == 16'h1)
         begin
            st <= 3'h2;
            tmr <= ERASE_CYC;
         end
         // erase end, error only when asked for
         else if ((st == 3'h2 || st == 3'h4) && tmr == 16'h1)
         begin
            done <= 1'b1;
            err <= fail;
            st <= 3'h0;
         end
         if (wr)
         begin
            seq <= 3'h0; // a broken sequence drops to read
            // reset cancels sequence and window, not a suspend
            if (dq == 16'h00F0)
            begin
               if (st == 3'h1)
                  st <= 3'h0;
            end
            // suspend: chip erase is deaf to it
            else if (dq == 16'h00B0 && (st == 3'h1 || st == 3'h2))
            begin
               st <= 3'h3;
               tmr <= 16'h0;
            end
            else if (dq == 16'h0030 && st == 3'h3)
            begin
               st <= 3'h2; // resume
               tmr <= ERASE_CYC;
            end
            else if (dq == 16'h0030 && st == 3'h1)
               tmr <= SEL_CYC; // extra block restarts window
            else if (st == 3'h0)
               case (seq)
                  3'h0, 3'h3: if (a555 && dq == 16'h00AA) seq <= seq + 3'h1;
                  3'h1, 3'h4: if (addr[11:0] == 12'h2AA && dq == 16'h0055) seq <= seq + 3'h1;
                  3'h2: if (a555 && dq == 16'h0080) seq <= 3'h3;
                  3'h5:
                  begin
                     // sixth write: chip or first block
                     if (a555 && dq == 16'h0010)
                        st <= 3'h4;
                     if (a555 && dq == 16'h0010)
                        tmr <= ERASE_CYC;
                     if (dq == 16'h0030)
                        st <= 3'h1;
                     if (dq == 16'h0030)
                        tmr <= SEL_CYC;
                  end
                  default: seq <= 3'h0;
               endcase
         end
      end
   end
endmodule // fec_flash_model

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   reg clk;
   reg srst;
   reg cmd_valid;
   reg [2:0] cmd_op;
   reg [22:0] cmd_addr;
   reg fail; // ask the device for an erase error
   wire erase_done, erase_error, cmd_ready, cmd_accepted, cmd_rejected, status_reads;
   wire flash_ce_n, flash_we_n, flash_dq_oe_n;
   wire [2:0] mode;
   wire [22:0] flash_addr;
   wire [15:0] flash_dq_out;
   integer n_mismatch = 0;
   integer compares = 0;
   integer cyc = 0;
   integer i, k;
   // row: op, accept, mode, check status, status, fail, second block
   reg [11:0] rows [0:26];
   reg [11:0] r;
   // --------
   // design and device
   // --------
   fec_erase_host #(.SEL_TIMEOUT_CYC(40), .SUSP_LAT_CYC(10)) u_dut (.clk(clk), .srst(srst),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .erase_done(erase_done),
      .erase_error(erase_error), .cmd_ready(cmd_ready), .cmd_accepted(cmd_accepted),
      .cmd_rejected(cmd_rejected), .mode(mode), .status_reads(status_reads),
      .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_addr(flash_addr),
      .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n));
   fec_flash_model u_dev (.clk(clk), .srst(srst), .ce_n(flash_ce_n), .we_n(flash_we_n),
      .addr(flash_addr), .dq(flash_dq_out), .fail(fail), .done(erase_done),
      .err(erase_error));
   // --------
   // tasks
   // --------
   task check(input [22:0] seen, input [22:0] exp);
   begin
      compares = compares + 1;
      if (seen !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   end
   endtask
   // hold the request until an answer, bounded
   task issue(input [2:0] op, input [22:0] a, input acc);
   begin
      cmd_op <= op;
      cmd_addr <= a;
      cmd_valid <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k = k + 1;
      end
      while (cmd_accepted !== 1'b1 && cmd_rejected !== 1'b1 && k < 2000);
      cmd_valid <= 1'b0;
      check(cmd_accepted, acc);
      check(k >= 2000, 1'b0);
   end
   endtask
   task wait_mode(input [2:0] m, input integer lim);
   begin
      k = 0;
      while (mode !== m && k < lim)
      begin
         @(posedge clk);
         k = k + 1;
      end
      check(mode, m);
   end
   endtask
   task tally_and_finish;
   begin
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   // --------
   // clock and hang guard
   // --------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch = n_mismatch + 1;
         tally_and_finish;
      end
   end
   // --------
   // main sequence
   // --------
   initial
   begin
      srst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = 3'h0;
      cmd_addr = 23'h000000;
      fail = 1'b0;
      rows[0] = 12'h110;
      rows[1] = 12'h310;
      rows[2] = 12'h530;
      rows[3] = 12'h420;
      rows[4] = 12'h740;
      rows[5] = 12'h640;
      rows[6] = 12'h120;
      rows[7] = 12'h110;
      rows[8] = 12'h978;
      rows[9] = 12'hC10;
      rows[10] = 12'h964;
      rows[11] = 12'h61C;
      rows[12] = 12'h618;
      rows[13] = 12'h110;
      rows[14] = 12'hB80;
      rows[15] = 12'hB82;
      rows[16] = 12'hDC0;
      rows[17] = 12'h1C0;
      rows[18] = 12'h530;
      rows[19] = 12'h1C0;
      rows[20] = 12'hFA0;
      rows[21] = 12'h8A0;
      rows[22] = 12'hDC0;
      rows[23] = 12'hFA0;
      rows[24] = 12'h010;
      rows[25] = 12'hB80;
      rows[26] = 12'h110;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      check(mode, 3'h0);
      for (i = 0; i < 27; i = i + 1)
      begin
         r = rows[i];
         fail <= r[2];
         issue(r[11:9], r[1] ? 23'h180000 : 23'h100000, r[8]);
         // let the whole write sequence finish before looking at status
         k = 0;
         while (cmd_ready !== 1'b1 && k < 2000)
         begin
            @(posedge clk);
            k = k + 1;
         end
         check(cmd_ready, 1'b1);
         wait_mode(r[7:5], 900);
         @(posedge clk);
         if (r[4])
            check(status_reads, r[3]);
      end
      // reset lands in the middle of a chip erase sequence
      fail <= 1'b0;
      cmd_op <= 3'h4;
      cmd_valid <= 1'b1;
      repeat (5) @(posedge clk);
      cmd_valid <= 1'b0;
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      check(mode, 3'h0);
      check({flash_ce_n, flash_we_n, flash_dq_oe_n}, 3'h7);
      issue(3'h0, 23'h100000, 1'b1);
      // catch the single reset write on the pins while the strobe is low
      k = 0;
      while (flash_we_n !== 1'b0 && k < 50)
      begin
         @(posedge clk);
         k = k + 1;
      end
      check(flash_dq_out, 23'h0000F0);
      check(flash_addr, 23'h100000);
      wait_mode(3'h0, 50);
      tally_and_finish;
   end
endmodule // tb_top
